//--- src/uart_core_pkg.sv
// constants and types for the serial port core
package uart_core_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [2:0] OFF_DATA = 3'h0;
   localparam logic [2:0] OFF_IRQ_EN = 3'h1;
   localparam logic [2:0] OFF_FIFO_CTRL = 3'h2;
   localparam logic [2:0] OFF_LINE_FORMAT = 3'h3;
   localparam logic [2:0] OFF_LOOPBACK = 3'h4;
   localparam logic [2:0] OFF_LINE_STATUS = 3'h5;
   localparam logic [2:0] OFF_SCRATCH = 3'h7;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int LOOP_BIT = 4;
   localparam int DIV_ACCESS_BIT = 7;
   localparam int BREAK_BIT = 6;
   localparam int STICK_BIT = 5;
   localparam int EVEN_BIT = 4;
   localparam int PAR_EN_BIT = 3;
   localparam int STOP2_BIT = 2;
   localparam int RX_IRQ_EN_BIT = 0;
   localparam int TX_IRQ_EN_BIT = 1;
   localparam int FIFO_EN_BIT = 0;
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_THR_EMPTY_BIT = 5;
   localparam int STAT_TX_IDLE_BIT = 6;
   // ----------------------------------------
   // reset values and sizes
   // ----------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_DIVISOR = 16'h0000;
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] FIFO_FULL_CNT = 5'h10;
   localparam logic [4:0] SINGLE_CNT = 5'h01;
   // ----------------------------------------
   // sample-tick timing per bit
   // ----------------------------------------
   localparam logic [5:0] TICKS_BIT = 6'h10;
   localparam logic [5:0] TICKS_STOP_HALF = 6'h18;
   localparam logic [5:0] TICKS_STOP_TWO = 6'h20;
   localparam logic [5:0] TICKS_MID = 6'h08;
   localparam int BASE_CHAR_BITS = 5;
   // ----------------------------------------
   // state machines
   // ----------------------------------------
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PAR = 3'b011,
      TX_STOP = 3'b100
   } tx_state_e;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } rx_state_e;
   // ----------------------------------------
   // host register access
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } host_req_s;
endpackage

//--- src/uart_loopback_baud_fifo_core.sv
// serial port core: loopback, baud generator, byte fifos, scratch
//
// Functional notes
// [R1] control register is 8 bits; only bit 4 acts.
// [R2] loopback set forces the transmit pin high.
// [R3] loopback set ignores receive pin; transmit shifter feeds receiver.
// [R4] baud generator divides input clock by divisor 1 to 65535.
// [R5] generator output runs at sixteen times the bit rate.
// [R6] divisor held in two writable 8-bit latches, one 16-bit value.
// [R7] writing either divisor latch reloads the baud counter at once.
// [R8] host writes both divisor latches before using serial transfers.
// [R9] receive buffer is a 16-byte fifo timed by the 16x clock.
// [R10] receive shifter assembles serial bits and pushes characters.
// [R11] line format register sets length, stop bits and parity.
// [R12] non-fifo mode: received character with enable bit 0 raises interrupt.
// [R13] non-fifo mode: reading the character withdraws that interrupt.
// [R14] fifo mode: interrupts follow fifo control configuration.
// [R15] 8-bit scratch register stored and returned, no other effect.
// [R16] transmit holding is a 16-byte fifo filled from the host.
// [R17] next character moves to transmit shifter only when it is idle.
// [R18] non-fifo mode: empty holding with enable bit 1 raises interrupt.
// [R19] non-fifo mode: loading a character clears that interrupt.
// [R20] divisor latches reached only with access bit 7 set.
// [R21] two low format bits select five to eight data bits.
// [R22] loopback resets cleared.
`timescale 1ns/1ps
module uart_loopback_baud_fifo_core (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host register port
   input wire uart_core_pkg::host_req_s host_req,
   output logic [7:0] reg_rdata,
   output logic irq,
   // serial lines
   input wire logic serial_rx_pin,
   output logic serial_tx_pin
);
   import uart_core_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] char_mask(input logic [1:0] len);
      char_mask = 8'h1F;
      case (len)
         2'b01: char_mask = 8'h3F;
         2'b10: char_mask = 8'h7F;
         2'b11: char_mask = 8'hFF;
         default: char_mask = 8'h1F;
      endcase
   endfunction

   function automatic logic [2:0] last_bit(input logic [1:0] len);
      last_bit = 3'(BASE_CHAR_BITS - 1) + 3'(len);
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] line_loopback_control;
   logic [7:0] line_format_control;
   logic [7:0] irq_enable;
   logic [7:0] fifo_ctrl;
   logic [7:0] scratchpad;
   logic [7:0] div_lo;
   logic [7:0] div_hi;
   logic [15:0] baud_cnt;
   logic baud_tick;

   logic divisor_access_select;
   logic loop_on;
   logic fifo_mode;
   logic rx_data_irq_enable;
   logic tx_empty_irq_enable;
   logic wr_data;
   logic rd_data;
   logic [4:0] fifo_cap;

   assign divisor_access_select = line_format_control[DIV_ACCESS_BIT];
   assign loop_on = line_loopback_control[LOOP_BIT]; // [R1]
   assign fifo_mode = fifo_ctrl[FIFO_EN_BIT];
   assign rx_data_irq_enable = irq_enable[RX_IRQ_EN_BIT];
   assign tx_empty_irq_enable = irq_enable[TX_IRQ_EN_BIT];
   assign fifo_cap = fifo_mode ? FIFO_FULL_CNT : SINGLE_CNT;
   assign wr_data = host_req.wr && host_req.addr == OFF_DATA &&
                    !divisor_access_select; // [R20]
   assign rd_data = host_req.rd && host_req.addr == OFF_DATA &&
                    !divisor_access_select; // [R20]

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         line_loopback_control <= RST_BYTE; // [R22]
         line_format_control <= RST_BYTE;
         irq_enable <= RST_BYTE;
         fifo_ctrl <= RST_BYTE;
         scratchpad <= RST_BYTE;
         div_lo <= RST_DIVISOR[7:0];
         div_hi <= RST_DIVISOR[15:8];
      end else if (host_req.wr) begin
         if (host_req.addr == OFF_DATA && divisor_access_select) begin
            div_lo <= host_req.wdata; // [R6] [R20]
         end else if (host_req.addr == OFF_IRQ_EN &&
                      divisor_access_select) begin
            div_hi <= host_req.wdata; // [R6] [R20]
         end else if (host_req.addr == OFF_IRQ_EN) begin
            irq_enable <= host_req.wdata;
         end else if (host_req.addr == OFF_FIFO_CTRL) begin
            fifo_ctrl <= host_req.wdata; // [R14]
         end else if (host_req.addr == OFF_LINE_FORMAT) begin
            line_format_control <= host_req.wdata; // [R11]
         end else if (host_req.addr == OFF_LOOPBACK) begin
            line_loopback_control <= host_req.wdata; // [R1]
         end else if (host_req.addr == OFF_SCRATCH) begin
            scratchpad <= host_req.wdata; // [R15]
         end
      end
   end

   // ----------------------------------------
   // baud generator
   // ----------------------------------------
   logic div_write;
   logic [15:0] next_divisor;

   assign div_write = host_req.wr && divisor_access_select &&
                      (host_req.addr == OFF_DATA ||
                       host_req.addr == OFF_IRQ_EN);
   always_comb begin
      next_divisor = {div_hi, div_lo};
      if (div_write && host_req.addr == OFF_DATA) begin
         next_divisor = {div_hi, host_req.wdata};
      end else if (div_write) begin
         next_divisor = {host_req.wdata, div_lo};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         baud_cnt <= RST_DIVISOR;
         baud_tick <= 1'b0;
      end else if (div_write) begin
         baud_cnt <= next_divisor; // [R7]
         baud_tick <= 1'b0;
      end else if ({div_hi, div_lo} == 16'h0000) begin
         baud_cnt <= 16'h0000; // divisor zero: generator stopped [R4]
         baud_tick <= 1'b0;
      end else if (baud_cnt <= 16'h0001) begin
         baud_cnt <= {div_hi, div_lo}; // [R4] [R5]
         baud_tick <= 1'b1;
      end else begin
         baud_cnt <= baud_cnt - 16'h0001;
         baud_tick <= 1'b0;
      end
   end

   // ----------------------------------------
   // transmit holding fifo
   // ----------------------------------------
   logic [7:0] tx_mem [FIFO_DEPTH];
   logic [3:0] tx_wptr;
   logic [3:0] tx_rptr;
   logic [4:0] tx_count;
   logic tx_push;
   logic tx_pop;
   tx_state_e tx_state;

   assign tx_push = wr_data && tx_count < fifo_cap; // [R16]
   assign tx_pop = tx_state == TX_IDLE && tx_count != 5'h00; // [R17]

   always_ff @(posedge clk) begin
      if (tx_push) begin
         tx_mem[tx_wptr] <= host_req.wdata; // [R16]
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_wptr <= 4'h0;
         tx_rptr <= 4'h0;
         tx_count <= 5'h00;
      end else begin
         if (tx_push) begin
            tx_wptr <= tx_wptr + 4'h1;
         end
         if (tx_pop) begin
            tx_rptr <= tx_rptr + 4'h1;
         end
         tx_count <= tx_count + 5'(tx_push) - 5'(tx_pop); // [R19]
      end
   end

   // ----------------------------------------
   // transmit shifter
   // ----------------------------------------
   logic [7:0] transmit_shifter;
   logic [5:0] tx_ticks;
   logic [2:0] tx_bit;
   logic tx_line;
   logic [5:0] stop_len;

   always_comb begin
      stop_len = TICKS_BIT;
      if (line_format_control[STOP2_BIT]) begin
         stop_len = (line_format_control[1:0] == 2'b00) ?
                    TICKS_STOP_HALF : TICKS_STOP_TWO; // [R11]
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_state <= TX_IDLE;
         transmit_shifter <= RST_BYTE;
         tx_ticks <= 6'h00;
         tx_bit <= 3'h0;
         tx_line <= 1'b1;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               tx_line <= 1'b1;
               if (tx_pop) begin
                  transmit_shifter <= tx_mem[tx_rptr]; // [R17]
                  tx_state <= TX_START;
                  tx_ticks <= 6'h00;
               end
            end
            TX_START: begin
               tx_line <= 1'b0;
               if (baud_tick) begin
                  tx_ticks <= tx_ticks + 6'h01;
                  if (tx_ticks == TICKS_BIT - 6'h01) begin
                     tx_ticks <= 6'h00;
                     tx_bit <= 3'h0;
                     tx_state <= TX_DATA;
                  end
               end
            end
            TX_DATA: begin
               tx_line <= transmit_shifter[tx_bit];
               if (baud_tick) begin
                  tx_ticks <= tx_ticks + 6'h01;
                  if (tx_ticks == TICKS_BIT - 6'h01) begin
                     tx_ticks <= 6'h00;
                     tx_bit <= tx_bit + 3'h1;
                     if (tx_bit == last_bit(line_format_control[1:0])) begin
                        tx_state <= line_format_control[PAR_EN_BIT] ?
                                    TX_PAR : TX_STOP; // [R21] [R11]
                     end
                  end
               end
            end
            TX_PAR: begin
               if (line_format_control[STICK_BIT]) begin
                  tx_line <= !line_format_control[EVEN_BIT]; // [R11]
               end else begin
                  tx_line <= ^(transmit_shifter &
                               char_mask(line_format_control[1:0])) ^
                             !line_format_control[EVEN_BIT]; // [R11]
               end
               if (baud_tick) begin
                  tx_ticks <= tx_ticks + 6'h01;
                  if (tx_ticks == TICKS_BIT - 6'h01) begin
                     tx_ticks <= 6'h00;
                     tx_state <= TX_STOP;
                  end
               end
            end
            TX_STOP: begin
               tx_line <= 1'b1;
               if (baud_tick) begin
                  tx_ticks <= tx_ticks + 6'h01;
                  if (tx_ticks == stop_len - 6'h01) begin
                     tx_ticks <= 6'h00;
                     tx_state <= TX_IDLE;
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         serial_tx_pin <= 1'b1;
      end else if (loop_on) begin
         serial_tx_pin <= 1'b1; // [R2]
      end else if (line_format_control[BREAK_BIT]) begin
         serial_tx_pin <= 1'b0;
      end else begin
         serial_tx_pin <= tx_line;
      end
   end

   // ----------------------------------------
   // receive shifter
   // ----------------------------------------
   logic rx_in;
   logic [7:0] receive_shifter;
   logic [5:0] rx_ticks;
   logic [2:0] rx_bit;
   logic rx_done;
   rx_state_e rx_state;

   assign rx_in = loop_on ? tx_line : serial_rx_pin; // [R3]

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_state <= RX_IDLE;
         receive_shifter <= RST_BYTE;
         rx_ticks <= 6'h00;
         rx_bit <= 3'h0;
         rx_done <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (baud_tick) begin // [R9]
            rx_ticks <= rx_ticks + 6'h01;
            case (rx_state)
               RX_IDLE: begin
                  rx_ticks <= 6'h00;
                  if (!rx_in) begin
                     rx_state <= RX_START;
                  end
               end
               RX_START: begin
                  if (rx_ticks == TICKS_MID - 6'h01) begin
                     rx_ticks <= 6'h00;
                     rx_bit <= 3'h0;
                     receive_shifter <= RST_BYTE;
                     rx_state <= rx_in ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (rx_ticks == TICKS_BIT - 6'h01) begin
                     rx_ticks <= 6'h00;
                     receive_shifter[rx_bit] <= rx_in; // [R10]
                     rx_bit <= rx_bit + 3'h1;
                     if (rx_bit == last_bit(line_format_control[1:0])) begin
                        rx_state <= line_format_control[PAR_EN_BIT] ?
                                    RX_PAR : RX_STOP; // [R21] [R11]
                     end
                  end
               end
               RX_PAR: begin
                  if (rx_ticks == TICKS_BIT - 6'h01) begin
                     rx_ticks <= 6'h00;
                     rx_state <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (rx_ticks == TICKS_BIT - 6'h01) begin
                     rx_ticks <= 6'h00;
                     rx_done <= 1'b1; // [R10]
                     rx_state <= RX_IDLE;
                  end
               end
               default: rx_state <= RX_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // receive buffer fifo
   // ----------------------------------------
   logic [7:0] rx_mem [FIFO_DEPTH];
   logic [3:0] rx_wptr;
   logic [3:0] rx_rptr;
   logic [4:0] rx_count;
   logic rx_push;
   logic rx_pop;

   assign rx_push = rx_done && rx_count < fifo_cap; // [R9]
   assign rx_pop = rd_data && rx_count != 5'h00; // [R13]

   always_ff @(posedge clk) begin
      if (rx_push) begin
         rx_mem[rx_wptr] <= receive_shifter; // [R10]
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_wptr <= 4'h0;
         rx_rptr <= 4'h0;
         rx_count <= 5'h00;
      end else begin
         if (rx_push) begin
            rx_wptr <= rx_wptr + 4'h1;
         end
         if (rx_pop) begin
            rx_rptr <= rx_rptr + 4'h1;
         end
         rx_count <= rx_count + 5'(rx_push) - 5'(rx_pop);
      end
   end

   // ----------------------------------------
   // interrupt request
   // ----------------------------------------
   logic tx_holding_empty;
   logic [4:0] rx_trigger;
   logic rx_irq;
   logic tx_irq;

   assign tx_holding_empty = tx_count == 5'h00;
   always_comb begin
      case (fifo_ctrl[7:6])
         2'b01: rx_trigger = 5'h04;
         2'b10: rx_trigger = 5'h08;
         2'b11: rx_trigger = 5'h0E;
         default: rx_trigger = 5'h01;
      endcase
   end
   // fifo mode: receive level reaches trigger, transmit fifo empty [R14]
   assign rx_irq = fifo_mode ? (rx_count >= rx_trigger) :
                   (rx_count != 5'h00); // [R12] [R13]
   assign tx_irq = tx_holding_empty; // [R18] [R19]

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= (rx_irq && rx_data_irq_enable) ||
                (tx_irq && tx_empty_irq_enable); // [R12] [R18]
      end
   end

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= RST_BYTE;
      end else if (host_req.rd) begin
         if (host_req.addr == OFF_DATA && divisor_access_select) begin
            reg_rdata <= div_lo; // [R20]
         end else if (host_req.addr == OFF_DATA) begin
            reg_rdata <= rx_count != 5'h00 ? rx_mem[rx_rptr] : RST_BYTE;
         end else if (host_req.addr == OFF_IRQ_EN &&
                      divisor_access_select) begin
            reg_rdata <= div_hi; // [R20]
         end else if (host_req.addr == OFF_IRQ_EN) begin
            reg_rdata <= irq_enable;
         end else if (host_req.addr == OFF_FIFO_CTRL) begin
            reg_rdata <= fifo_ctrl;
         end else if (host_req.addr == OFF_LINE_FORMAT) begin
            reg_rdata <= line_format_control;
         end else if (host_req.addr == OFF_LOOPBACK) begin
            reg_rdata <= line_loopback_control;
         end else if (host_req.addr == OFF_LINE_STATUS) begin
            reg_rdata <= RST_BYTE;
            reg_rdata[STAT_READY_BIT] <= rx_count != 5'h00;
            reg_rdata[STAT_THR_EMPTY_BIT] <= tx_holding_empty;
            reg_rdata[STAT_TX_IDLE_BIT] <= tx_holding_empty &&
                                            tx_state == TX_IDLE;
         end else if (host_req.addr == OFF_SCRATCH) begin
            reg_rdata <= scratchpad; // [R15]
         end else begin
            reg_rdata <= RST_BYTE;
         end
      end
   end
endmodule

//--- tb/uart_core_props.sv
// assertion checker for the serial port core
`timescale 1ns/1ps
module uart_core_props
   import uart_core_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host port
   input wire uart_core_pkg::host_req_s host_req,
   input wire logic [7:0] reg_rdata,
   input wire logic irq,
   // serial lines
   input wire logic serial_rx_pin,
   input wire logic serial_tx_pin
);
   // ------
   // shadow of host writes
   // ------
   logic [7:0] fmt, ier, fctl, loop, scr, dlo, dhi;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {fmt, ier, fctl, loop} <= '0;
         {scr, dlo, dhi} <= '0;
      end else if (host_req.wr) begin
         case (host_req.addr)
            OFF_DATA: if (fmt[DIV_ACCESS_BIT]) dlo <= host_req.wdata;
            OFF_IRQ_EN: begin
               if (fmt[DIV_ACCESS_BIT]) dhi <= host_req.wdata;
               else ier <= host_req.wdata;
            end
            OFF_FIFO_CTRL: fctl <= host_req.wdata;
            OFF_LINE_FORMAT: fmt <= host_req.wdata;
            OFF_LOOPBACK: loop <= host_req.wdata;
            OFF_SCRATCH: scr <= host_req.wdata;
            default: ;
         endcase
      end
   end
   // ------
   // properties
   // ------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence read_of(logic [2:0] o);
      host_req.rd && host_req.addr == o;
   endsequence
   sequence plain_rx_read;
      read_of(OFF_DATA) ##0 !fmt[DIV_ACCESS_BIT] && !fctl[FIFO_EN_BIT];
   endsequence
   reset_idle_a: assert property ($fell(sys_rst) |->
      serial_tx_pin && !irq && reg_rdata == RST_BYTE)
      else $error("outputs not idle after reset");
   loop_tx_high_a: assert property (
      loop[LOOP_BIT] && $past(loop[LOOP_BIT], 3) |-> serial_tx_pin)
      else $error("transmit pin low in loopback");
   scratch_back_a: assert property (
      read_of(OFF_SCRATCH) |=> reg_rdata == $past(scr))
      else $error("scratch read mismatch");
   div_low_a: assert property (
      read_of(OFF_DATA) ##0 fmt[DIV_ACCESS_BIT] |=> reg_rdata == $past(dlo))
      else $error("divisor low mismatch");
   div_high_a: assert property (
      read_of(OFF_IRQ_EN) ##0 fmt[DIV_ACCESS_BIT] |=> reg_rdata == $past(dhi))
      else $error("divisor high mismatch");
   loop_bit_a: assert property (read_of(OFF_LOOPBACK) |=>
      reg_rdata[LOOP_BIT] == $past(loop[LOOP_BIT]))
      else $error("loopback bit mismatch");
   low_run_a: assert property (
      $fell(serial_tx_pin) |-> (!serial_tx_pin) [*8])
      else $error("transmit low run too short");
   high_run_a: assert property (
      $rose(serial_tx_pin) |-> serial_tx_pin [*8])
      else $error("transmit high run too short");
   irq_quiet_a: assert property (
      ier[1:0] == 2'h0 && $past(ier[1:0], 2) == 2'h0 |-> !irq)
      else $error("interrupt while disabled");
   rx_clear_a: assert property (
      plain_rx_read ##0 ier[1:0] == 2'h1 |-> ##2 !irq)
      else $error("interrupt kept after read");
endmodule
bind uart_loopback_baud_fifo_core uart_core_props i_uart_core_props (
   .clk, .sys_rst, .host_req, .reg_rdata, .irq, .serial_rx_pin,
   .serial_tx_pin);

//--- tb/serial_partner.sv
// far-end serial device model on the link
`timescale 1ns/1ps
module serial_partner (
   // clock
   input wire logic clk,
   // serial lines
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;
   // ------
   // start, lsb-first data, stop; idle high
   // ------
   task automatic level(input logic v);
      @(posedge clk);
      line_out <= v;
   endtask
   task automatic send(input logic [7:0] d, input int n, input int per);
      int i;
      level(1'b0);
      for (i = 0; i <= n; i++) begin
         repeat (per - 1) @(posedge clk);
         level(i < n ? d[i] : 1'b1);
      end
      repeat (per) @(posedge clk);
   endtask
   task automatic recv(input int per, output logic [7:0] d);
      int i;
      for (i = 0; i < 1000 && line_in; i++) @(posedge clk);
      repeat (per / 2) @(posedge clk);
      for (i = 0; i < 8; i++) begin
         repeat (per) @(posedge clk);
         d[i] = line_in;
      end
   endtask
endmodule

//--- tb/test_uart_loopback_baud_fifo_core.sv
// self-checking bench for the serial port core
`timescale 1ns/1ps
module test_uart_loopback_baud_fifo_core;
   import uart_core_pkg::*;
   typedef struct packed {
      logic [2:0] a;
      logic [7:0] d;
      logic [7:0] m;
      logic [7:0] e;
   } row_s;
   logic clk, sys_rst, rx, tx, irq;
   host_req_s req;
   logic [7:0] rdata, v;
   int fail_count, checked, i, k;
   row_s rows [9];
   uart_loopback_baud_fifo_core i_uart_loopback_baud_fifo_core (
      .clk(clk), .sys_rst(sys_rst), .host_req(req), .reg_rdata(rdata),
      .irq(irq), .serial_rx_pin(rx), .serial_tx_pin(tx));
   serial_partner i_serial_partner (.clk(clk), .line_in(tx), .line_out(rx));
   // ------
   // tasks
   // ------
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic reset_pulse;
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1 cmp({6'h00, irq, tx}, 8'h01);
      cmp(rdata, RST_BYTE);
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
   // ------
   // main sequence
   // ------
   initial begin
      req = '0;
      fail_count = 0;
      checked = 0;
      rows = '{{3'h3, 8'h80, 8'hFF, 8'h80}, {3'h0, 8'h01, 8'hFF, 8'h01},
         {3'h1, 8'h00, 8'hFF, 8'h00}, {3'h3, 8'h03, 8'hFF, 8'h03},
         {3'h7, 8'hA5, 8'hFF, 8'hA5}, {3'h7, 8'h5A, 8'hFF, 8'h5A},
         {3'h4, 8'hEF, 8'h10, 8'h00}, {3'h4, 8'h10, 8'h10, 8'h10},
         {3'h6, 8'h55, 8'hFF, 8'h00}};
      reset_pulse();
      foreach (rows[j]) begin
         wr(rows[j].a, rows[j].d);
         rd(rows[j].a, v);
         cmp(v & rows[j].m, rows[j].e);
      end
      wr(3'h4, 8'h00);
      for (k = 0; k < 4; k++) begin
         wr(3'h3, 8'(k));
         i_serial_partner.send(8'hB5, 5 + k, 16);
         repeat (20) @(posedge clk);
         rd(3'h0, v);
         cmp(v, 8'hB5 & (8'hFF >> (3 - k)));
      end
      wr(3'h3, 8'h83);
      wr(3'h0, 8'h02);
      wr(3'h3, 8'h03);
      wr(3'h0, 8'h4B);
      i_serial_partner.recv(32, v);
      cmp(v, 8'h4B);
      repeat (100) @(posedge clk);
      wr(3'h3, 8'h83);
      wr(3'h0, 8'h01);
      wr(3'h3, 8'h03);
      wr(3'h1, 8'h01);
      i_serial_partner.send(8'h3C, 8, 16);
      repeat (20) @(posedge clk);
      cmp({7'h00, irq}, 8'h01);
      rd(3'h0, v);
      cmp(v, 8'h3C);
      repeat (2) @(posedge clk);
      cmp({7'h00, irq}, 8'h00);
      wr(3'h1, 8'h02);
      repeat (3) @(posedge clk);
      cmp({7'h00, irq}, 8'h01);
      wr(3'h0, 8'h00);
      @(posedge clk);
      #1 cmp({7'h00, irq}, 8'h00);
      repeat (200) @(posedge clk);
      wr(3'h1, 8'h01);
      wr(3'h2, 8'hC1);
      wr(3'h4, 8'h10);
      i_serial_partner.level(1'b0);
      for (i = 0; i < 17; i++)
         wr(3'h0, 8'(i) * 8'h25);
      repeat (100) @(posedge clk);
      cmp({7'h00, tx}, 8'h01);
      repeat (2900) @(posedge clk);
      cmp({7'h00, irq}, 8'h01);
      for (i = 0; i < 16; i++) begin
         rd(3'h0, v);
         cmp(v, 8'(i) * 8'h25);
      end
      rd(3'h0, v);
      cmp(v, 8'h00);
      cmp({7'h00, irq}, 8'h00);
      wr(3'h3, 8'h1F);
      wr(3'h0, 8'h96);
      repeat (250) @(posedge clk);
      rd(3'h0, v);
      cmp(v, 8'h96);
      @(posedge clk);
      reset_pulse();
      rd(3'h4, v);
      cmp(v, 8'h00);
      print_verdict();
   end
endmodule
